// ---- core/wsra_arbiter.sv ----
// write-status arbitration stage, the device end
`timescale 1ns/1ps
module wsra_arbiter
    import wsra_pkg::*;
#(
    parameter int NS = NUM_SLAVES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // link
    wsra_if.arb lnk
);
    logic [SLV_SEL_W-1:0] prio;
    logic [NS-1:0] grant;
    logic [SLV_SEL_W-1:0] grant_idx;
    logic any_offer;

    // --------------------------------------------------------------------
    // rotating pick, combinational so the grant lands in the offer cycle
    // --------------------------------------------------------------------
    always_comb
    begin
        logic found;
        int k;
        k = 0;
        found = 1'b0;
        grant = '0;
        grant_idx = '0;
        for (int i = 0; i < NS; i++)
        begin
            k = (int'(prio) + i) % NS;
            if (!found && lnk.st_valid[k] && lnk.st_eot[k])
            begin
                found = 1'b1;
                grant[k] = 1'b1;
                grant_idx = SLV_SEL_W'(k);
            end
        end
    end

    assign any_offer = |grant;
    // losers see not-ready whenever several offer at once
    assign lnk.st_ready = grant;
    // forwarding is combinational; a registered path would cost a
    // cycle and break same-cycle acceptance
    assign lnk.fwd_valid = any_offer;
    assign lnk.fwd_tag = lnk.st_tag[grant_idx*TAG_W +: TAG_W];

    // --------------------------------------------------------------------
    // priority pointer moves past the last winner
    // --------------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
            prio <= PRIO_RST;
        else if (any_offer)
            prio <= grant_idx + 1'b1;
    end
endmodule // wsra_arbiter

// ---- core/wsra_ends.sv ----
// core master tag pool and a bank of well-behaved slave endpoints
`timescale 1ns/1ps
module wsra_ends
    import wsra_pkg::*;
#(
    parameter int NS = NUM_SLAVES
)
(
    // clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // user request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [SLV_SEL_W-1:0] req_slave,
    output logic req_taken,
    output logic stalled,
    // link
    wsra_if.ends lnk
);
    logic [POOL_N-1:0] busy;
    logic [1:0] slot;
    logic [TAG_W-1:0] cur_tag;
    logic [NS-1:0] pend;
    logic [NS*TAG_W-1:0] pend_tag;
    logic issue;
    logic blocked;
    logic [POOL_N-1:0] ret_hit;
    logic ret_ok;

    // --------------------------------------------------------------------
    // master issue: tag C..F in rotation, blocked on an outstanding tag
    // --------------------------------------------------------------------
    assign cur_tag = TAG_FIRST + TAG_W'(slot);
    assign ret_ok = lnk.fwd_valid && lnk.fwd_tag >= TAG_FIRST;
    assign blocked = busy[slot] && !(ret_ok && lnk.fwd_tag == cur_tag);
    assign issue = req_valid && !blocked;

    assign lnk.cmd_valid = issue;
    assign lnk.cmd_write = req_write;
    assign lnk.cmd_tag = cur_tag;
    assign lnk.cmd_slave = req_slave;

    generate
        for (genvar t = 0; t < POOL_N; t++)
        begin : g_pool
            assign ret_hit[t] = ret_ok &&
                lnk.fwd_tag == TAG_FIRST + TAG_W'(t);
            always_ff @(posedge clock or posedge sys_rst)
            begin
                if (sys_rst)
                    busy[t] <= 1'b0;
                else if (issue && req_write && slot == 2'(t))
                    busy[t] <= 1'b1;
                else if (ret_hit[t])
                    busy[t] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            slot <= SLOT_RST;
            req_taken <= 1'b0;
            stalled <= 1'b0;
        end
        else
        begin
            if (issue)
                slot <= slot + 1'b1;
            req_taken <= issue;
            // lost status shows after three more transactions
            stalled <= req_valid && blocked;
        end
    end

    // --------------------------------------------------------------------
    // slaves: one held status each, kept until granted or replaced by a newer accepted write
    // --------------------------------------------------------------------
    generate
        for (genvar s = 0; s < NS; s++)
        begin : g_slv
            logic accept;
            assign accept = issue && req_write && req_slave == SLV_SEL_W'(s);
            assign lnk.st_valid[s] = pend[s];
            assign lnk.st_eot[s] = pend[s];
            assign lnk.st_tag[s*TAG_W +: TAG_W] = pend_tag[s*TAG_W +: TAG_W];
            always_ff @(posedge clock or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    pend[s] <= 1'b0;
                    pend_tag[s*TAG_W +: TAG_W] <= '0;
                end
                else if (accept)
                begin
                    pend[s] <= 1'b1;
                    pend_tag[s*TAG_W +: TAG_W] <= cur_tag;
                end
                else if (lnk.st_ready[s])
                    pend[s] <= 1'b0;
            end
        end
    endgenerate
endmodule // wsra_ends

// ---- pkg/wsra_if.sv ----
// interface joining the status arbiter end and the slave/master end
`timescale 1ns/1ps
interface wsra_if
    import wsra_pkg::*;
#(
    parameter int NS = NUM_SLAVES
);
    // per-slave completion offers
    logic [NS-1:0] st_valid;
    logic [NS*TAG_W-1:0] st_tag;
    logic [NS-1:0] st_eot;
    // per-slave ready from the arbiter
    logic [NS-1:0] st_ready;
    // forwarded completion toward the master
    logic fwd_valid;
    logic [TAG_W-1:0] fwd_tag;
    // master issue side
    logic cmd_valid;
    logic cmd_write;
    logic [TAG_W-1:0] cmd_tag;
    logic [SLV_SEL_W-1:0] cmd_slave;

    modport arb (
        input st_valid, st_tag, st_eot,
        output st_ready, fwd_valid, fwd_tag,
        input cmd_valid, cmd_write, cmd_tag, cmd_slave
    );
    modport ends (
        output st_valid, st_tag, st_eot,
        input st_ready, fwd_valid, fwd_tag,
        output cmd_valid, cmd_write, cmd_tag, cmd_slave
    );
endinterface

// ---- pkg/wsra_pkg.sv ----
// shared constants for the write-status return arbiter
package wsra_pkg;
    localparam int TAG_W = 4;
    localparam logic [3:0] TAG_FIRST = 4'hC;
    localparam logic [3:0] TAG_LAST = 4'hF;
    localparam int POOL_N = 4;
    localparam int NUM_SLAVES = 4;
    localparam int SLV_SEL_W = 2;
    localparam logic [3:0] POOL_BUSY_RST = 4'h0;
    localparam logic [1:0] SLOT_RST = 2'h0;
    localparam logic [1:0] PRIO_RST = 2'h0;
endpackage

// ---- verif/tb.sv ----
// self-checking bench for the write-status return arbiter
`timescale 1ns/1ps
module tb;
    import wsra_pkg::*;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic [1:0] req_slave = 2'h0;
    logic req_taken;
    logic stalled;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    wsra_if lnk ();
    wsra_arbiter wsra_arbiter_inst (.clock(clock), .sys_rst(sys_rst),
        .lnk(lnk));
    wsra_ends wsra_ends_inst (.clock(clock), .sys_rst(sys_rst),
        .req_valid(req_valid), .req_write(req_write), .req_slave(req_slave),
        .req_taken(req_taken), .stalled(stalled), .lnk(lnk));
    wsra_monitor wsra_monitor_inst (.clock(clock), .sys_rst(sys_rst),
        .st_valid(lnk.st_valid), .st_ready(lnk.st_ready),
        .fwd_valid(lnk.fwd_valid), .cmd_valid(lnk.cmd_valid),
        .cmd_tag(lnk.cmd_tag));
    initial
    begin
        forever #10 clock = ~clock;
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // bound well above the few dozen cycles the tests need
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            give_verdict();
        end
    end
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_reset();
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (5) @(posedge clock);
        sys_rst <= 1'b0;
    endtask
    // back-to-back issues; status of each write must show one cycle later
    task automatic burst(logic [5:0] wr);
        logic [3:0] tag;
        logic [3:0] prev;
        for (int i = 0; i <= 6; i++)
        begin
            @(posedge clock);
            req_valid <= (i < 6);
            req_write <= wr[i % 6];
            req_slave <= 2'(i);
            @(negedge clock);
            tag = {2'b11, 2'(i)};
            prev = {2'b11, 2'(i + 3)};
            if (i < 6)
                check("cmd", {lnk.cmd_write, lnk.cmd_valid, lnk.cmd_tag},
                    {2'h0, wr[i], 1'b1, tag});
            if (i > 0)
            begin
                check("req_taken", req_taken, 8'h01);
                check("fwd_valid", lnk.fwd_valid, wr[i - 1]);
                if (wr[i - 1])
                    check("fwd_tag", lnk.fwd_tag, prev);
            end
        end
        check("stalled", stalled, 0);
    endtask
    task automatic test_rotation();
        burst(6'h3B);
        $display("test_rotation done");
    endtask
    task automatic test_reset_restart();
        do_reset();
        burst(6'h2F);
        $display("test_reset_restart done");
    endtask
    initial
    begin
        do_reset();
        test_rotation();
        test_reset_restart();
        give_verdict();
    end
endmodule // tb

// ---- verif/wsra_monitor.sv ----
// assertions watching the status return link
`timescale 1ns/1ps
module wsra_monitor
    import wsra_pkg::*;
#(
    parameter int NS = NUM_SLAVES
)
(
    // clock and reset
    input logic clock,
    input logic sys_rst,
    // link
    input logic [NS-1:0] st_valid,
    input logic [NS-1:0] st_ready,
    input logic fwd_valid,
    input logic cmd_valid,
    input logic [TAG_W-1:0] cmd_tag
);
    // ----------------
    // helper logic
    // ----------------
    // reset to the slot before C so the first issue must carry C
    logic [1:0] last_slot;
    always_ff @(posedge clock or posedge sys_rst)
        if (sys_rst)
            last_slot <= 2'h3;
        else if (cmd_valid)
            last_slot <= cmd_tag[1:0];
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ----------------
    // properties
    // ----------------
    a_grant_one_hot: assert property ($onehot0(st_ready))
        else $error("more than one slave granted");
    a_ready_needs_offer: assert property ((st_ready & ~st_valid) == '0)
        else $error("ready given to an idle slave");
    a_offer_granted: assert property (|st_valid |-> |st_ready)
        else $error("offers present but none granted");
    a_contend_refuse: assert property (!$onehot0(st_valid)
        |-> (st_valid & ~st_ready) != '0)
        else $error("contention without not-ready");
    a_fwd_same_cycle: assert property (|st_ready |-> fwd_valid)
        else $error("granted status not forwarded");
    a_fwd_needs_grant: assert property (fwd_valid |-> |st_ready)
        else $error("status forwarded without grant");
    a_refused_kept: assert property ((st_valid & ~st_ready) != '0
        |=> ($past(st_valid & ~st_ready) & ~st_valid) == '0)
        else $error("refused status dropped");
    a_tag_rotate: assert property (cmd_valid
        |-> cmd_tag == {2'b11, 2'(last_slot + 2'h1)})
        else $error("tag out of pool order");
    c_contend: cover property ($countones(st_valid) > 1);
    c_grant: cover property (|st_ready);
    c_issue: cover property (cmd_valid ##1 cmd_valid);
endmodule // wsra_monitor
